// ### core/mad_datapath.sv
// multiply-accumulate datapath: accumulate, multiply, data move and aux update
// assumes memory reads are presented as words by the surrounding sequencer;
// placement inputs say where operands and code live for cycle costs and the move gate
`timescale 1ns/1ps
`include "mad_cfg.svh"

module mad_datapath (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire mad_pkg::mad_op_t op,
  input wire logic [15:0] opcode,
  input wire logic [15:0] pma,
  input wire logic [15:0] pc_in,
  input wire logic [8:0] dp,
  input wire logic [15:0] rpt_count,
  input wire logic [15:0] data_word,
  input wire logic [15:0] prog_word,
  input wire logic [1:0] product_shift_mode,
  input wire logic overflow_mode,
  input wire logic op2_ext,
  input wire logic op2_mmr,
  input wire logic op2_single_access_ram,
  input wire logic ops_same_block,
  input wire logic code_same_block,
  input wire logic [15:0] aux_index,
  output logic busy,
  output logic done,
  output logic [15:0] data_addr,
  output logic [15:0] prog_addr,
  output logic move_we,
  output logic [15:0] move_addr,
  output logic [15:0] move_data,
  output logic [15:0] pc_out,
  output logic [15:0] multiplicand_reg,
  output logic [31:0] product_reg,
  output logic [31:0] accumulator,
  output logic carry_flag,
  output logic overflow_flag,
  output logic [2:0] aux_pointer,
  output logic [2:0] aux_pointer_buffer,
  output logic [15:0] aux_reg_cur
);
  import mad_pkg::*;

  // ==========================================================
  // functions
  function automatic logic [31:0] shift_prod(input logic [31:0] p, input logic [1:0] m);
    logic [31:0] r;
    r = p;
    unique case (m)
      2'h0: r = p;
      2'h1: r = {p[30:0], 1'b0};
      2'h2: r = {p[27:0], 4'h0};
      2'h3: r = {{6{p[31]}}, p[31:6]};
    endcase
    return r;
  endfunction

  function automatic logic [31:0] smul(input logic [15:0] a, input logic [15:0] b);
    logic signed [31:0] r;
    r = $signed(a) * $signed(b);
    return r;
  endfunction

  function automatic logic [15:0] ar_step(input logic [15:0] a, input logic [15:0] ix,
                                          input mad_aru_t u);
    logic [15:0] r;
    logic [15:0] ra;
    logic [15:0] rx;
    logic [15:0] rs;
    r = a;
    // bit-reversed operands: the carry runs from the top bit downwards
    ra = {<<{a}};
    rx = {<<{ix}};
    rs = 16'h0000;
    unique case (u)
      MAD_ARU_NONE, MAD_ARU_RSV: r = a;
      MAD_ARU_DEC: r = a - 16'h0001;
      MAD_ARU_INC: r = a + 16'h0001;
      MAD_ARU_DEC0: r = a - ix;
      MAD_ARU_INC0: r = a + ix;
      MAD_ARU_BRD: begin
        rs = ra - rx;
        r = {<<{rs}};
      end
      MAD_ARU_BRI: begin
        rs = ra + rx;
        r = {<<{rs}};
      end
    endcase
    return r;
  endfunction

  // ==========================================================
  // sequencer
  mad_state_t state_ff;
  mad_state_t nxt_state;
  mad_op_t op_ff;
  logic [15:0] opcode_ff;
  logic [15:0] rpt_ff;
  logic [3:0] wait_ff;
  logic [15:0] pc_ff;
  logic [15:0] stack_ff;
  logic [15:0] paddr_ff;
  logic [15:0] daddr_ff;
  logic [15:0] multiplicand_reg_ff;
  logic [31:0] product_reg_ff;
  logic [31:0] acc_ff;
  logic c_ff;
  logic ov_ff;
  logic [2:0] arp_ff;
  logic [2:0] arb_ff;
  logic [15:0] ar_ff [8];
  logic we_ff;
  logic [15:0] waddr_ff;
  logic [15:0] wdata_ff;
  logic done_ff;
  logic indirect;
  logic step;
  logic last;
  logic has_move;
  logic [3:0] pre_wait;
  logic [3:0] per_wait;
  logic [32:0] sum;
  logic [31:0] sat;
  logic [31:0] sprod;
  mad_aru_t aux_update_field;

  assign indirect = opcode_ff[`MAD_IND_BIT];
  assign aux_update_field = mad_aru_t'(opcode_ff[`MAD_ARU_LSB +: 3]);
  assign step = (state_ff == MAD_ST_RUN);
  assign last = step && (rpt_ff == 16'h0000);
  // no move on mapped or external operand
  assign has_move = (op_ff == MAD_OP_MAC_WITH_DATA_MOVE) && !op2_ext && !op2_mmr;

  always_comb begin
    pre_wait = 4'h0;
    if (op_ff == MAD_OP_MAC_WITH_DATA_MOVE || op_ff == MAD_OP_MACN) begin
      pre_wait = 4'h2;
      if (rpt_ff == 16'h0000 && op2_single_access_ram && ops_same_block)
        pre_wait = code_same_block ? 4'h4 : 4'h3;
      // repeated move with operand 2 alone in single-access ram: 2n in total
      else if (rpt_ff != 16'h0000 && op_ff == MAD_OP_MAC_WITH_DATA_MOVE && op2_single_access_ram && !ops_same_block)
        pre_wait = 4'h1;
    end else if (op_ff != MAD_OP_MAR && op2_single_access_ram && code_same_block) begin
      pre_wait = 4'h1;
    end
  end

  always_comb begin
    per_wait = 4'h0;
    if (rpt_ff != 16'h0000 && op_ff == MAD_OP_MAC_WITH_DATA_MOVE && op2_single_access_ram)
      per_wait = ops_same_block ? 4'h2 : 4'h1;
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      MAD_ST_IDLE: if (start) nxt_state = MAD_ST_FETCH;
      MAD_ST_FETCH: nxt_state = (pre_wait == 4'h0) ? MAD_ST_RUN : MAD_ST_WAIT;
      MAD_ST_WAIT: if (wait_ff == 4'h1) nxt_state = MAD_ST_RUN;
      MAD_ST_RUN: begin
        if (last) nxt_state = MAD_ST_DONE;
        else if (per_wait != 4'h0) nxt_state = MAD_ST_WAIT;
      end
      MAD_ST_DONE: nxt_state = MAD_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) state_ff <= MAD_ST_IDLE;
    else state_ff <= nxt_state;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      op_ff <= MAD_OP_NONE;
      opcode_ff <= 16'h0000;
      rpt_ff <= 16'h0000;
      wait_ff <= 4'h0;
    end else if (state_ff == MAD_ST_IDLE && start) begin
      op_ff <= op;
      opcode_ff <= opcode;
      rpt_ff <= rpt_count;
    end else if (state_ff == MAD_ST_FETCH) begin
      wait_ff <= pre_wait;
    end else if (state_ff == MAD_ST_WAIT) begin
      wait_ff <= wait_ff - 4'h1;
    end else if (step && !last) begin
      rpt_ff <= rpt_ff - 16'h0001;
      wait_ff <= per_wait;
    end
  end

  // ==========================================================
  // program counter, micro stack, operand addresses
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pc_ff <= 16'h0000;
      stack_ff <= 16'h0000;
      paddr_ff <= 16'h0000;
      daddr_ff <= 16'h0000;
    end else if (state_ff == MAD_ST_IDLE && start) begin
      pc_ff <= pc_in + 16'h0001;
      daddr_ff <= opcode[`MAD_IND_BIT] ? ar_ff[arp_ff] : {dp, opcode[6:0]};
      if (op == MAD_OP_MAC_WITH_DATA_MOVE || op == MAD_OP_MACN) begin
        stack_ff <= pc_in + 16'h0002;
        paddr_ff <= pma;
      end
    end else if (step) begin
      paddr_ff <= paddr_ff + 16'h0001;
      if (indirect) daddr_ff <= ar_step(ar_ff[arp_ff], aux_index, aux_update_field);
      if (last && (op_ff == MAD_OP_MAC_WITH_DATA_MOVE || op_ff == MAD_OP_MACN)) pc_ff <= stack_ff;
      else if (last) pc_ff <= pc_ff;
    end
  end

  // ==========================================================
  // arithmetic
  assign sprod = shift_prod(product_reg_ff, product_shift_mode);
  assign sum = {1'b0, acc_ff} + {1'b0, sprod};
  always_comb begin
    sat = sum[31:0];
    if (overflow_mode && (acc_ff[31] == sprod[31]) && (sum[31] != acc_ff[31]))
      sat = acc_ff[31] ? `MAD_ACC_MIN : `MAD_ACC_MAX;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      multiplicand_reg_ff <= `MAD_MULTIPLICAND_REG_RST;
      product_reg_ff <= `MAD_PRODUCT_REG_RST;
      acc_ff <= `MAD_ACC_RST;
      c_ff <= 1'b0;
      ov_ff <= 1'b0;
    end else if (step) begin
      unique case (op_ff)
        MAD_OP_MAC_WITH_DATA_MOVE, MAD_OP_MACN, MAD_OP_MULTIPLY_AND_ACCUMULATE: begin
          acc_ff <= sat;
          c_ff <= sum[32];
          if ((acc_ff[31] == sprod[31]) && (sum[31] != acc_ff[31])) ov_ff <= 1'b1;
          if (op_ff == MAD_OP_MULTIPLY_AND_ACCUMULATE) begin
            product_reg_ff <= smul(multiplicand_reg_ff, data_word);
          end else begin
            multiplicand_reg_ff <= data_word;
            product_reg_ff <= smul(data_word, prog_word);
          end
        end
        MAD_OP_MPY: product_reg_ff <= smul(multiplicand_reg_ff, data_word);
        MAD_OP_MPYK: product_reg_ff <= smul(multiplicand_reg_ff, {{3{opcode_ff[12]}}, opcode_ff[12:0]});
        default: product_reg_ff <= product_reg_ff;
      endcase
    end
  end

  // ==========================================================
  // auxiliary registers and pointer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < 8; i++) ar_ff[i] <= `MAD_AR_RST;
      arp_ff <= `MAD_ARP_RST;
      arb_ff <= `MAD_ARP_RST;
    end else if (step && indirect && op_ff != MAD_OP_MPYK && op_ff != MAD_OP_NONE) begin
      ar_ff[arp_ff] <= ar_step(ar_ff[arp_ff], aux_index, aux_update_field);
      if (opcode_ff[`MAD_NFLAG_BIT]) begin
        // next pointer selects one of eight
        arp_ff <= opcode_ff[`MAD_NAR_LSB +: 3];
        arb_ff <= arp_ff;
      end
    end
  end

  // ==========================================================
  // data move write
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      we_ff <= 1'b0;
      waddr_ff <= 16'h0000;
      wdata_ff <= 16'h0000;
      done_ff <= 1'b0;
    end else begin
      we_ff <= step && has_move;
      waddr_ff <= daddr_ff + 16'h0001;
      wdata_ff <= data_word;
      done_ff <= last;
    end
  end

  assign busy = (state_ff != MAD_ST_IDLE);
  assign done = done_ff;
  assign data_addr = daddr_ff;
  assign prog_addr = paddr_ff;
  assign move_we = we_ff;
  assign move_addr = waddr_ff;
  assign move_data = wdata_ff;
  assign pc_out = pc_ff;
  assign multiplicand_reg = multiplicand_reg_ff;
  assign product_reg = product_reg_ff;
  assign accumulator = acc_ff;
  assign carry_flag = c_ff;
  assign overflow_flag = ov_ff;
  assign aux_pointer = arp_ff;
  assign aux_pointer_buffer = arb_ff;
  assign aux_reg_cur = ar_ff[arp_ff];
endmodule

// ### core/mad_cfg.svh
// constants for the multiply-accumulate datapath
// assumes a single 100 MHz clock and a memory sequencer outside the block
`ifndef MAD_CFG_SVH
`define MAD_CFG_SVH

`define MAD_IND_BIT 7
`define MAD_NAR_LSB 0
`define MAD_NFLAG_BIT 3
`define MAD_ARU_LSB 4
`define MAD_ACC_RST 32'h0000_0000
`define MAD_PRODUCT_REG_RST 32'h0000_0000
`define MAD_MULTIPLICAND_REG_RST 16'h0000
`define MAD_AR_RST 16'h0000
`define MAD_ARP_RST 3'h0
`define MAD_ACC_MAX 32'h7FFF_FFFF
`define MAD_ACC_MIN 32'h8000_0000
`define MAD_PERIOD_NS 10
`define MAD_STEP_NS 10
`define MAD_STEP_CYC ((`MAD_STEP_NS + `MAD_PERIOD_NS - 1) / `MAD_PERIOD_NS)

`endif

// ### core/mad_pkg.sv
// types for the multiply-accumulate datapath
// assumes the constants header is included by the design file
package mad_pkg;
  typedef enum logic [2:0] {
    MAD_OP_NONE = 3'h0,
    MAD_OP_MAC_WITH_DATA_MOVE = 3'h1,
    MAD_OP_MACN = 3'h2,
    MAD_OP_MAR = 3'h3,
    MAD_OP_MPY = 3'h4,
    MAD_OP_MPYK = 3'h5,
    MAD_OP_MULTIPLY_AND_ACCUMULATE = 3'h6
  } mad_op_t;

  typedef enum logic [2:0] {
    MAD_ARU_NONE = 3'h0,
    MAD_ARU_DEC = 3'h1,
    MAD_ARU_INC = 3'h2,
    MAD_ARU_RSV = 3'h3,
    MAD_ARU_DEC0 = 3'h4,
    MAD_ARU_INC0 = 3'h5,
    MAD_ARU_BRD = 3'h6,
    MAD_ARU_BRI = 3'h7
  } mad_aru_t;

  typedef enum logic [4:0] {
    MAD_ST_IDLE = 5'h01,
    MAD_ST_FETCH = 5'h02,
    MAD_ST_WAIT = 5'h04,
    MAD_ST_RUN = 5'h08,
    MAD_ST_DONE = 5'h10
  } mad_state_t;
endpackage

// ### dv/mad_mem_model.sv
// far-side memory model: data and program words for the datapath
// assumes reads answer at once from the address outputs
`timescale 1ns/1ps
module mad_mem_model (
  input wire logic clk,
  input wire logic [15:0] data_addr,
  input wire logic [15:0] prog_addr,
  input wire logic move_we,
  input wire logic [15:0] move_addr,
  input wire logic [15:0] move_data,
  output logic [15:0] data_word,
  output logic [15:0] prog_word
);
  logic [15:0] dmem [256];
  logic [15:0] pmem [256];
  // =====
  // contents
  // program block mapped
  initial begin
    for (int i = 0; i < 256; i++) begin
      dmem[i] = 16'h0100 + 16'(i);
      pmem[i] = 16'h0010 + 16'(i);
    end
  end
  assign data_word = dmem[data_addr[7:0]];
  assign prog_word = pmem[prog_addr[7:0]];
  always @(posedge clk) begin
    if (move_we) begin
      dmem[move_addr[7:0]] <= move_data;
    end
  end
endmodule

// ### dv/mad_datapath_checker.sv
// port checker for the multiply-accumulate datapath
// assumes op and placement stay steady until done
`timescale 1ns/1ps
module mad_datapath_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire mad_pkg::mad_op_t op,
  input wire logic op2_ext,
  input wire logic op2_mmr,
  input wire logic busy,
  input wire logic done,
  input wire logic move_we,
  input wire logic [15:0] multiplicand_reg,
  input wire logic [31:0] product_reg,
  input wire logic [31:0] accumulator,
  input wire logic carry_flag,
  input wire logic overflow_flag,
  input wire logic [2:0] aux_pointer,
  input wire logic [2:0] aux_pointer_buffer
);
  import mad_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // =====
  // handshake
  take_busy_a: assert property (start && !busy |=> busy)
    else $error("busy not raised");
  done_pulse_a: assert property (done |=> !done)
    else $error("done too long");
  done_bound_a: assert property (start && !busy |-> ##[1:40] done)
    else $error("done missing");
  // =====
  // datapath
  move_gate_a: assert property (move_we |-> op == MAD_OP_MAC_WITH_DATA_MOVE && !op2_ext && !op2_mmr)
    else $error("bad move");
  ptr_buffer_a: assert property ($changed(aux_pointer) |->
    aux_pointer_buffer == $past(aux_pointer))
    else $error("buffer wrong");
  mpy_keep_a: assert property (busy && (op == MAD_OP_MPY || op == MAD_OP_MPYK) |=>
    $stable(accumulator) && $stable(carry_flag))
    else $error("acc changed");
  mar_keep_a: assert property (busy && op == MAD_OP_MAR |=>
    $stable(product_reg) && $stable(accumulator) && !move_we)
    else $error("modify touched data");
  multiplicand_reg_keep_a: assert property (busy && op == MAD_OP_MULTIPLY_AND_ACCUMULATE |=> $stable(multiplicand_reg))
    else $error("multiplicand_reg changed");
  ovf_sticky_a: assert property (overflow_flag |=> overflow_flag)
    else $error("overflow lost");
endmodule
bind mad_datapath mad_datapath_checker i_chk (.*);

// ### dv/multiply_accumulate_datapath_bench.sv
// self-checking bench for the multiply-accumulate datapath
// assumes the memory model answers at once and the checker is bound
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
  $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module multiply_accumulate_datapath_bench;
  import mad_pkg::*;
  logic clk = 0, reset_n = 0, start = 0, overflow_mode = 0, op2_ext = 0, op2_mmr = 0;
  logic op2_single_access_ram = 0, ops_same_block = 0, code_same_block = 0, busy, done, move_we;
  logic carry_flag, overflow_flag, e_c = 0;
  mad_op_t op = MAD_OP_NONE;
  logic [15:0] opcode = 0, pma = 16'h0020, pc_in = 0, rpt_count = 0, data_word, prog_word;
  logic [15:0] aux_index = 0, data_addr, prog_addr, move_addr, move_data, pc_out;
  logic [15:0] multiplicand_reg, aux_reg_cur, e_t = 0;
  logic [8:0] dp = 9'h006;
  logic [1:0] product_shift_mode = 0;
  logic [31:0] product_reg, accumulator, e_p = 0, e_a = 0;
  logic [2:0] aux_pointer, aux_pointer_buffer;
  int errors = 0, cmp_count = 0, n;
  mad_datapath i_dut (.*);
  mad_mem_model i_mem (.*);
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // =====
  // shared steps
  task automatic go(input mad_op_t o, input logic [15:0] oc, input logic [15:0] rc);
    @(negedge clk);
    op = o;
    opcode = oc;
    rpt_count = rc;
    start = 1;
    @(negedge clk);
    start = 0;
    n = 1;
    while (done !== 1'b1) begin
      if (n > 60) begin
        errors++;
        print_verdict();
      end
      @(negedge clk);
      n++;
    end
  endtask
  task automatic acc_add();
    logic [32:0] s;
    s = {1'b0, e_a} + {1'b0, (product_shift_mode == 2'h1) ? {e_p[30:0], 1'b0} : e_p};
    e_a = s[31:0];
    e_c = s[32];
  endtask
  // =====
  // scenarios
  task automatic mac(input mad_op_t o, input logic [7:0] off, input logic [15:0] rc,
                     input logic [4:0] pl, input int cyc);
    logic [15:0] d1;
    d1 = i_mem.dmem[off + 8'h01];
    {op2_ext, op2_mmr, op2_single_access_ram, ops_same_block, code_same_block} = pl;
    go(o, {8'h00, 1'b0, off[6:0]}, rc);
    for (int k = 0; k <= int'(rc); k++) begin
      acc_add();
      e_t = 16'h0100 + 16'(off);
      e_p = e_t * (16'h0030 + 16'(k));
    end
    `CHK(multiplicand_reg, e_t)
    `CHK(product_reg, e_p)
    `CHK(accumulator, e_a)
    `CHK(carry_flag, e_c)
    `CHK(pc_out, pc_in + 16'h0002)
    `CHK(prog_addr, pma + rc + 16'h0001)
    `CHK(data_addr, {dp, off[6:0]})
    // the copy reaches memory on the edge that ends the done cycle
    @(negedge clk);
    `CHK(i_mem.dmem[off + 8'h01], (o == MAD_OP_MAC_WITH_DATA_MOVE && pl[4:3] == 0) ? e_t : d1)
    // n also counts the fetch cycle and the done cycle
    if (cyc > 0) `CHK(n - 2, cyc)
    $display("test mac done");
  endtask
  task automatic mpy_test();
    int n1;
    go(MAD_OP_MPY, 16'h0040, 0);
    n1 = n;
    e_p = e_t * 16'h0140;
    `CHK(product_reg, e_p)
    `CHK(accumulator, e_a)
    {op2_single_access_ram, code_same_block} = 2'b11;
    go(MAD_OP_MPY, 16'h0041, 0);
    `CHK(n, n1 + 1)
    {op2_single_access_ram, code_same_block} = 2'b00;
    go(MAD_OP_MPYK, 16'h1FFF, 0);
    e_p = -{16'h0000, e_t};
    `CHK(product_reg, e_p)
    go(MAD_OP_MULTIPLY_AND_ACCUMULATE, 16'h0044, 0);
    acc_add();
    e_p = e_t * 16'h0144;
    `CHK(accumulator, e_a)
    `CHK(carry_flag, e_c)
    `CHK(overflow_flag, 1'b0)
    `CHK(product_reg, e_p)
    `CHK(multiplicand_reg, e_t)
    $display("test multiply done");
  endtask
  task automatic mar_test();
    logic [2:0] prev;
    go(MAD_OP_MAR, 16'h0000, 0);
    `CHK(aux_pointer, 3'h0)
    `CHK(product_reg, e_p)
    `CHK(pc_out, pc_in + 16'h0001)
    for (int i = 7; i >= 0; i--) begin
      prev = aux_pointer;
      go(MAD_OP_MAR, 16'h0088 | 16'(i), 0);
      `CHK(aux_pointer, 3'(i))
      `CHK(aux_pointer_buffer, prev)
    end
    go(MAD_OP_MAR, 16'h00A0, 0);
    `CHK(aux_reg_cur, 16'h0001)
    `CHK(accumulator, e_a)
    $display("test modify done");
  endtask
  initial begin
    repeat (8) @(negedge clk);
    reset_n = 1;
    mac(MAD_OP_MAC_WITH_DATA_MOVE, 8'h08, 0, 5'b00000, 3);
    mac(MAD_OP_MAC_WITH_DATA_MOVE, 8'h0C, 0, 5'b00110, 4);
    mac(MAD_OP_MAC_WITH_DATA_MOVE, 8'h10, 0, 5'b00111, 5);
    product_shift_mode = 2'h1;
    mac(MAD_OP_MAC_WITH_DATA_MOVE, 8'h14, 0, 5'b10000, 0);
    mac(MAD_OP_MAC_WITH_DATA_MOVE, 8'h18, 0, 5'b01000, 0);
    mac(MAD_OP_MACN, 8'h1C, 0, 5'b00000, 0);
    mac(MAD_OP_MAC_WITH_DATA_MOVE, 8'h20, 2, 5'b00000, 5);
    mac(MAD_OP_MAC_WITH_DATA_MOVE, 8'h24, 2, 5'b00100, 6);
    mac(MAD_OP_MAC_WITH_DATA_MOVE, 8'h28, 2, 5'b00110, 9);
    mac(MAD_OP_MAC_WITH_DATA_MOVE, 8'h2C, 1, 5'b10000, 0);
    product_shift_mode = 2'h0;
    mpy_test();
    mar_test();
    print_verdict();
  end
endmodule
